/* File: design/ttc_thermal_throttle.sv */
// Summary of operation
// - Trip reached drives hot line active
// - Trip cleared releases own hot drive
// - Hot assertion ignores every control setting
// - Throttling starts on the same trip
// - Trip threshold fixed, not run-time writable
// - Throttling stops and restarts clocks, fixed duty
// - Clock-off interval at most about 3 us
// - External low on hot line forces throttling
// - Hot indication visible internally and on pin
// - Throttling disabled after reset until enabled
// - Release only after time-based hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "ttc_defines.svh"

module ttc_thermal_throttle (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   // Factory-calibrated trip comparator and enable bit
   input  wire logic                  tripReached,
   input  wire logic                  throttleEnable,
   // Open-drain die_hot_n line
   input  wire logic                  dieHotIn,
   output var  ttc_pkg::ttc_hot_pin_t dieHotPin,
   // Internal view and core clock control
   output var  logic                  dieHotInt,
   output var  logic                  throttleActive,
   output var  logic                  coreClkOff
);
   import ttc_pkg::*;

   ttc_state_t s_r;
   ttc_state_t s_nxt;
   logic       extHot;
   logic [7:0] lowRun_r;

   // Own or external heat; internal view and throttle share one decode
   function automatic logic hotSeen(input ttc_heat_t heat,
                                    input logic      ext);
      return (heat != TTC_COOL) || ext;
   endfunction

   // External pull-low is only visible while we leave the line alone;
   // while we drive it our own heat already counts as hot
   assign extHot = !dieHotIn && !s_r.pin.oe;

   // Trip tracking with hysteresis and throttle request
   always_comb begin
      logic ownHot;
      ownHot = 1'b0;
      s_nxt  = s_r;
      unique case (s_r.heat)
         TTC_COOL: begin
            // Threshold lives in the comparator, nothing here can move it
            if (tripReached) begin
               s_nxt.heat = TTC_HOT;
            end
         end
         TTC_HOT: begin
            if (!tripReached) begin
               s_nxt.heat    = TTC_HYST;
               s_nxt.hystCnt = 8'(`TTC_HYST_CYC - 1);
            end
         end
         TTC_HYST: begin
            if (tripReached) begin
               s_nxt.heat = TTC_HOT;
            end else if (s_r.hystCnt == 8'h00) begin
               s_nxt.heat = TTC_COOL;
            end else begin
               s_nxt.hystCnt = s_r.hystCnt - 8'h01;
            end
         end
         default: begin
            // Unused code: take the safe side and drive the line hot;
            // the normal release path then cools it down again
            s_nxt.heat = TTC_HOT;
         end
      endcase
      ownHot = (s_nxt.heat != TTC_COOL);
      // Hot drive does not look at the enable at all
      s_nxt.pin.oe    = ownHot;
      s_nxt.pin.level = `TTC_PIN_LEVEL_RST;
      s_nxt.hotInt    = hotSeen(s_nxt.heat, extHot);
      // Same condition as the internal hot view, gated only by the enable bit
      s_nxt.throttle  = throttleEnable
                        && hotSeen(s_nxt.heat, extHot);
   end

   // State register; reset leaves throttling off
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Clock-off pattern; fed the next value so it starts in the same cycle as throttleActive
   ttc_duty_timer u_timer (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .run     (s_nxt.throttle),
      .clkOff  (coreClkOff)
   );

   // Outputs straight from the state register
   assign dieHotPin      = s_r.pin;
   assign dieHotInt      = s_r.hotInt;
   assign throttleActive = s_r.throttle;

   // Run of consecutive cool samples, watched only by checks
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lowRun_r <= 8'h00;
      end else if (tripReached) begin
         lowRun_r <= 8'h00;
      end else if (lowRun_r != 8'hff) begin
         lowRun_r <= lowRun_r + 8'h01;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_trip_drives_hot: assert property (
      tripReached |=> dieHotPin.oe && dieHotInt)
      else $error("trip did not drive the hot line");

   a_release_after_hyst: assert property (
      (lowRun_r > 8'(`TTC_HYST_CYC)) |-> !dieHotPin.oe)
      else $error("hot drive held after hysteresis");

   a_hot_ignores_enable: assert property (
      (tripReached && !throttleEnable) |=> dieHotPin.oe && !throttleActive)
      else $error("hot drive depends on enable");

   a_throttle_with_trip: assert property (
      (tripReached && throttleEnable && !throttleActive)
      |=> throttleActive && coreClkOff)
      else $error("throttle did not start with trip");

   a_fixed_threshold: assert property (
      $rose(dieHotPin.oe) |-> $past(tripReached))
      else $error("hot drive rose without trip");

   a_hyst_hold: assert property (
      ($fell(tripReached) && dieHotPin.oe) |-> dieHotPin.oe[*8])
      else $error("hot drive released without hysteresis");

   a_ext_forces_throttle: assert property (
      (!dieHotIn && !dieHotPin.oe && throttleEnable)
      |=> throttleActive && dieHotInt)
      else $error("external request ignored");

   a_internal_view: assert property (
      dieHotPin.oe |-> dieHotInt)
      else $error("internal hot view missing");

   a_enable_gates: assert property (
      !throttleEnable |=> !throttleActive && !coreClkOff)
      else $error("throttle active while disabled");

   a_open_drain: assert property (
      dieHotPin.level == 1'b0)
      else $error("hot line driven high");

   // lowRun_r counts cool samples apart from the hysteresis counter,
   // so a wrong reload of hystCnt shows up here
   a_hold_in_hyst: assert property (
      (dieHotPin.oe && !tripReached && lowRun_r < 8'(`TTC_HYST_CYC))
      |=> dieHotPin.oe)
      else $error("hot drive released inside hysteresis");

   a_release_on_time: assert property (
      (dieHotPin.oe && !tripReached && lowRun_r == 8'(`TTC_HYST_CYC))
      |=> !dieHotPin.oe)
      else $error("hot drive not released after hysteresis");

   a_cool_stays_off: assert property (
      (!dieHotPin.oe && !tripReached) |=> !dieHotPin.oe)
      else $error("hot drive rose while cool");

   a_ext_release: assert property (
      (!dieHotPin.oe && dieHotIn && !tripReached) |=> !dieHotInt)
      else $error("external request held without a pull");

   a_ext_view: assert property (
      (!dieHotIn && !dieHotPin.oe) |=> dieHotInt)
      else $error("external pull not seen internally");

   a_throttle_needs_hot: assert property (
      throttleActive |-> dieHotInt)
      else $error("throttle without hot indication");

   a_clk_needs_throttle: assert property (
      coreClkOff |-> throttleActive)
      else $error("core clocks stopped without throttle");

   a_duty_starts_off: assert property (
      $rose(throttleActive) |-> coreClkOff)
      else $error("duty pattern did not start with clocks off");

   // Main scenarios, each to be seen at least once
   c_trip_throttle: cover property (
      tripReached && throttleEnable ##1 coreClkOff);

   c_ext_throttle: cover property (
      !dieHotIn && !dieHotPin.oe && throttleEnable ##1 throttleActive);

   c_hyst_release: cover property ($fell(dieHotPin.oe));

   c_ext_release: cover property (
      throttleActive && !dieHotPin.oe ##1 !throttleActive);

endmodule
`default_nettype wire

/* File: include/ttc_defines.svh */
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH

// Core clock rate in MHz (100 ns period)
`define TTC_CLK_MHZ       10

// Longest clock-off interval while throttling, ns (rounded down to cycles)
`define TTC_OFF_MAX_NS    3000
`define TTC_OFF_CYC       ((`TTC_OFF_MAX_NS * `TTC_CLK_MHZ) / 1000)

// Clock-on interval, ns; with the off interval it fixes the part's duty
`define TTC_ON_NS         3000
`define TTC_ON_CYC        ((`TTC_ON_NS * `TTC_CLK_MHZ + 999) / 1000)

// Least hysteresis before releasing the hot indication, ns (rounded up)
`define TTC_HYST_NS       2000
`define TTC_HYST_CYC      ((`TTC_HYST_NS * `TTC_CLK_MHZ + 999) / 1000)

// Reset values
`define TTC_PIN_LEVEL_RST 1'b0
`define TTC_CNT_RST       8'h00

`endif

/* File: include/ttc_pkg.sv */
package ttc_pkg;

   // Heat tracking of the trip comparison
   typedef enum logic [1:0] {
      TTC_COOL,
      TTC_HOT,
      TTC_HYST
   } ttc_heat_t;

   // Open-drain hot line, output half
   typedef struct packed {
      logic level;
      logic oe;
   } ttc_hot_pin_t;

   // Main block state
   typedef struct packed {
      ttc_heat_t    heat;
      logic [7:0]   hystCnt;
      ttc_hot_pin_t pin;
      logic         hotInt;
      logic         throttle;
   } ttc_state_t;

   // Duty timer state
   typedef struct packed {
      logic       running;
      logic       off;
      logic [7:0] cnt;
   } ttc_tmr_state_t;

endpackage

/* File: design/ttc_duty_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ttc_defines.svh"

module ttc_duty_timer (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // Throttle request
   input  wire logic run,
   // Core clock stop
   output var  logic clkOff
);
   import ttc_pkg::*;

   ttc_tmr_state_t t_r;
   ttc_tmr_state_t t_nxt;
   logic [7:0]     offLen_r;

   // Off first, then on, alternating with fixed lengths
   always_comb begin
      t_nxt         = t_r;
      t_nxt.running = run;
      if (!run) begin
         // Clocks resume at once when the request drops
         t_nxt.off = 1'b0;
         t_nxt.cnt = `TTC_CNT_RST;
      end else if (!t_r.running) begin
         t_nxt.off = 1'b1;
         t_nxt.cnt = 8'(`TTC_OFF_CYC - 1);
      end else if (t_r.cnt == 8'h00) begin
         t_nxt.off = !t_r.off;
         t_nxt.cnt = t_r.off ? 8'(`TTC_ON_CYC - 1)
                             : 8'(`TTC_OFF_CYC - 1);
      end else begin
         t_nxt.cnt = t_r.cnt - 8'h01;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         t_r <= '0;
      end else begin
         t_r <= t_nxt;
      end
   end

   assign clkOff = t_r.off;

   // Length of the current off stretch, watched only by checks
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         offLen_r <= 8'h00;
      end else begin
         offLen_r <= t_r.off ? offLen_r + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // The counter reads one full off stretch in the first cycle with clocks back on
   a_off_bounded: assert property (
      offLen_r <= 8'(`TTC_OFF_CYC))
      else $error("clock-off interval too long");

   a_on_reload: assert property (
      ($fell(t_r.off) && $past(run)) |-> t_r.cnt == 8'(`TTC_ON_CYC - 1))
      else $error("on interval not loaded with fixed length");

   // Only a stretch that ends while the request holds must be full length
   a_off_full: assert property (
      ($fell(t_r.off) && $past(run)) |-> offLen_r == 8'(`TTC_OFF_CYC))
      else $error("off interval cut short");

   c_full_period: cover property ($fell(t_r.off) && $past(run));

endmodule
`default_nettype wire

/* File: verif/ttc_board_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module ttc_board_monitor #(
   parameter int DELAY = 2
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // Regulator overheat and device drive
   input  wire logic vrHot,
   input  wire logic devOe,
   // Wire view
   output var  logic pulling,
   output var  logic dieHotN
);
   int cnt;

   // Slow monitor: pulls only after DELAY hot samples, releases at once
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         pulling <= 1'b0;
      end else begin
         cnt <= vrHot ? cnt + 1 : 0;
         pulling <= vrHot && (cnt >= DELAY);
      end
   end

   // Wired line, pull-up when nobody pulls low
   always_comb begin
      dieHotN = !(devOe || pulling);
   end
endmodule

`default_nettype wire

/* File: verif/ttc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ttc_defines.svh"
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

module testbench;
   import ttc_pkg::*;
   logic         clk_sys = 1'b0;
   logic         reset_n = 1'b0;
   logic         tripReached = 1'b0;
   logic         throttleEnable = 1'b0;
   logic         vrHot = 1'b0;
   logic         pulling, dieHotN, dieHotInt, throttleActive, coreClkOff;
   ttc_hot_pin_t dieHotPin;
   logic [35:0]  q[$];
   logic [35:0]  expv;
   logic [3:0]   vE = 4'h0, vNew, vNow, vPrev = 4'h0;
   logic         own, hot, thr, ext;
   int           low, ph, cyc = 0, mismatches = 0, nTests = 0, seed = 17058;
   int           len;

   always #50 clk_sys = ~clk_sys;

   ttc_thermal_throttle u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .tripReached(tripReached), .throttleEnable(throttleEnable),
      .dieHotIn(dieHotN), .dieHotPin(dieHotPin), .dieHotInt(dieHotInt),
      .throttleActive(throttleActive), .coreClkOff(coreClkOff));

   ttc_board_monitor #(.DELAY(2)) u_board (.clk_sys(clk_sys),
      .reset_n(reset_n), .vrHot(vrHot), .devOe(dieHotPin.oe),
      .pulling(pulling), .dieHotN(dieHotN));

   // Expected outputs per edge; only changes are noted
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         own = 1'b0; low = 0; thr = 1'b0; ph = 0; vE = 4'h0;
      end else begin
         cyc++;
         ext = pulling && !own;
         if (tripReached) begin
            own = 1'b1;
            low = 0;
         end else if (own) begin
            low++;
            if (low == `TTC_HYST_CYC + 1) own = 1'b0;
         end
         hot = own | ext;
         ph = (thr && hot && throttleEnable) ? ph + 1 : 0;
         thr = hot && throttleEnable;
         vNew = {own, hot, thr,
                 thr && ((ph % (`TTC_OFF_CYC + `TTC_ON_CYC)) < `TTC_OFF_CYC)};
         if (vNew !== vE) q.push_back({cyc[31:0], vNew});
         vE = vNew;
      end
   end

   // Every output change must match the oldest note, value and cycle
   always @(posedge clk_sys) begin
      #1;
      vNow = {dieHotPin.oe, dieHotInt, throttleActive, coreClkOff};
      if (vNow !== vPrev) begin
         expv = (q.size() > 0) ? q.pop_front() : '1;
         `CHK({cyc[31:0], vNow}, expv)
         `CHK(dieHotPin.level, 1'b0)
         vPrev = vNow;
      end
   end

   // Hold level inputs for n cycles
   task automatic drive(input logic t, input logic v, input logic e,
                        input int n);
      @(posedge clk_sys);
      tripReached <= t;
      vrHot <= v;
      throttleEnable <= e;
      repeat (n - 1) @(posedge clk_sys);
   endtask

   task automatic complete_run();
      `CHK(q.size(), 0)
      if (mismatches == 0 && nTests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Trip, trip with glitch in hysteresis, external pull; enable both ways
   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         len = 1 + ({$random(seed)} % 130);
         case (i % 3)
            0: drive(1'b1, 1'b0, i[0], len);
            1: begin
               drive(1'b1, 1'b0, i[0], len);
               drive(1'b0, 1'b0, i[0], 10);
               drive(1'b1, 1'b0, i[0], 3);
            end
            default: drive(1'b0, 1'b1, i[0], len);
         endcase
         drive(1'b0, 1'b0, i[0], 40);
      end
      complete_run();
   end

   // Hang guard, well beyond the longest sequence
   initial begin
      #(5000 * 100);
      mismatches++;
      complete_run();
   end
endmodule

`default_nettype wire
